// File: logic/lhi_pkg.sv
// Constants and types shared by the LCD host interface block
package lhi_pkg;
   // ------------------------------------------------------------
   // Data path widths
   // ------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int CNT_W = 3;
   localparam logic [2:0] CNT_LAST = 3'h7;
   localparam logic [2:0] CNT_RESET = 3'h0;
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_W = 9;
   // ------------------------------------------------------------
   // Display memory geometry
   // ------------------------------------------------------------
   localparam int ROWS = 65;
   localparam int COLS = 132;
   localparam int PAGES = 9;
   localparam int LAST_PAGE = 8;
   localparam int PAGE_W = 4;
   localparam int COL_W = 8;
   localparam int ROW_W = 7;
   localparam int ADDR_W = 11;
   // ------------------------------------------------------------
   // Bit positions on the host data bus
   // ------------------------------------------------------------
   localparam int BUSY_BIT = 7;
   localparam int SER_DATA_BIT = 7;
   localparam int SER_CLK_BIT = 6;
   localparam logic [3:0] STATUS_LOW = 4'h0;
   // ------------------------------------------------------------
   // Positions in the synchronised pin vector
   // ------------------------------------------------------------
   localparam int PIN_W = 16;
   localparam int PIN_CS_N = 8;
   localparam int PIN_CS_H = 9;
   localparam int PIN_PS = 10;
   localparam int PIN_C68 = 11;
   localparam int PIN_RS = 12;
   localparam int PIN_E = 13;
   localparam int PIN_RW = 14;
   localparam int PIN_RES = 15;
   localparam logic [15:0] PIN_RESET = 16'hc100;

   typedef enum logic [1:0] {LHI_SERIAL, LHI_P6800, LHI_P8080} lhi_port_type;
endpackage : lhi_pkg

// File: logic/lhi_host_port.sv
// Host port of the LCD controller with write FIFO and display memory
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Host transfers count only with low select low and high select high.
// - Deselected: ignore select, strobes; data bus never driven.
// - Serial deselected clears the 8-bit shift register and 3-bit counter.
// - Interface select high picks parallel port, low picks serial port.
// - Parallel 8-bit bus; style select high 6800 timing, low 8080.
// - Serial port only writes; nothing is returned over it.
// - Serial data on bus line 7, serial clock on line 6, when selected.
// - Serial data sampled on each rising serial clock edge.
// - Eighth serial edge hands over one byte and restarts the count.
// - Data/command select high marks display data, low a command.
// - Status read gives busy on bit 7; busy blocks parallel writes and display reads, not serial bytes.
// - Reset pin low initialises settings; acts on level, not edge.
// - Display memory of 65 by 132 bits; one lights a dot.
// ------------------------------------------------------------
// Write FIFO
// ------------------------------------------------------------
module lhi_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   logic [WIDTH-1:0] store [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;
   assign in_ready = count != FULL;
   assign out_valid = count != '0;
   assign out_data = store[rd_ptr];
   always_comb begin
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (push) begin
         next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
         next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (clk_en) begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (clk_en && push) begin
         store[wr_ptr] <= in_data;
      end
   end
endmodule : lhi_fifo
// ------------------------------------------------------------
// Host port top
// ------------------------------------------------------------
module lhi_host_port #(
   parameter int FIFO_DEPTH = lhi_pkg::FIFO_DEPTH
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic chip_select_low_n,
   input wire logic chip_select_high,
   input wire logic port_type_select,
   input wire logic bus_style_select,
   input wire logic data_or_command_select,
   input wire logic enable_or_read_strobe,
   input wire logic direction_or_write_strobe,
   input wire logic reset_input_low,
   input wire logic [7:0] host_data_bus_in,
   output logic [7:0] host_data_bus_out,
   output logic host_data_bus_oe_n,
   input wire logic core_busy,
   input wire logic [2:0] status_flags,
   output logic busy,
   output logic settings_init,
   output logic byte_valid,
   input wire logic byte_ready,
   output logic [7:0] byte_data,
   output logic byte_is_data,
   input wire logic mem_wr_en,
   input wire logic [3:0] mem_page,
   input wire logic [7:0] mem_col,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata,
   input wire logic [6:0] pix_row,
   input wire logic [7:0] pix_col,
   output logic pix_on
);
   logic [15:0] sync1, sync2, pins;
   logic prev_e, prev_wr, prev_sclk, prev_rd, next_prev_rd;
   logic [7:0] shift_reg, next_shift_reg;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic wr_valid, next_wr_valid;
   logic [7:0] wr_byte, next_wr_byte;
   logic wr_is_data, next_wr_is_data;
   logic [7:0] next_dout;
   logic next_oe_n, next_init;
   logic selected, res_ok, sclk_rise, rd_act, wr_edge, fifo_ready;
   logic [8:0] fifo_out;
   lhi_pkg::lhi_port_type port_mode;
   logic [7:0] dmem [lhi_pkg::PAGES * lhi_pkg::COLS];
   function automatic logic [10:0] lhi_addr(input logic [3:0] page, input logic [7:0] col);
      lhi_addr = 11'(page * lhi_pkg::COLS + col);
   endfunction : lhi_addr
   function automatic logic lhi_in_range(input logic [3:0] page, input logic [7:0] col);
      lhi_in_range = (page < lhi_pkg::PAGES) && (col < lhi_pkg::COLS);
   endfunction : lhi_in_range
   // ------------------------------------------------------------
   // Pin synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sync1 <= lhi_pkg::PIN_RESET;
         sync2 <= lhi_pkg::PIN_RESET;
      end else if (clk_en) begin
         sync1 <= {reset_input_low, direction_or_write_strobe, enable_or_read_strobe,
                   data_or_command_select, bus_style_select, port_type_select,
                   chip_select_high, chip_select_low_n, host_data_bus_in};
         sync2 <= sync1;
      end
   end
   assign pins = sync2;
   // ------------------------------------------------------------
   // Decode of mode and strobes
   // ------------------------------------------------------------
   always_comb begin
      selected = !pins[lhi_pkg::PIN_CS_N] && pins[lhi_pkg::PIN_CS_H];
      res_ok = pins[lhi_pkg::PIN_RES];
      if (!pins[lhi_pkg::PIN_PS]) begin
         port_mode = lhi_pkg::LHI_SERIAL;
      end else if (pins[lhi_pkg::PIN_C68]) begin
         port_mode = lhi_pkg::LHI_P6800;
      end else begin
         port_mode = lhi_pkg::LHI_P8080;
      end
      rd_act = 1'b0;
      wr_edge = 1'b0;
      case (port_mode)
         lhi_pkg::LHI_P6800: begin
            rd_act = pins[lhi_pkg::PIN_E] && pins[lhi_pkg::PIN_RW];
            wr_edge = !pins[lhi_pkg::PIN_E] && prev_e && !pins[lhi_pkg::PIN_RW];
         end
         lhi_pkg::LHI_P8080: begin
            rd_act = !pins[lhi_pkg::PIN_E];
            wr_edge = pins[lhi_pkg::PIN_RW] && !prev_wr;
         end
         default: begin
            rd_act = 1'b0;
            wr_edge = 1'b0;
         end
      endcase
      rd_act = rd_act && selected && res_ok;
      wr_edge = wr_edge && selected && res_ok;
      sclk_rise = pins[lhi_pkg::SER_CLK_BIT] && !prev_sclk;
      busy = core_busy || !fifo_ready;
   end
   // ------------------------------------------------------------
   // Receive, serial and parallel
   // ------------------------------------------------------------
   always_comb begin
      next_shift_reg = shift_reg;
      next_bit_cnt = bit_cnt;
      next_wr_valid = 1'b0;
      next_wr_byte = wr_byte;
      next_wr_is_data = wr_is_data;
      next_init = !res_ok;
      if (port_mode != lhi_pkg::LHI_SERIAL || !selected || !res_ok) begin
         next_shift_reg = lhi_pkg::SHIFT_RESET;
         next_bit_cnt = lhi_pkg::CNT_RESET;
      end else if (sclk_rise) begin
         next_shift_reg = {shift_reg[6:0], pins[lhi_pkg::SER_DATA_BIT]};
         next_bit_cnt = bit_cnt + 1'b1;
         if (bit_cnt == lhi_pkg::CNT_LAST) begin
            next_wr_valid = 1'b1;
            next_wr_byte = {shift_reg[6:0], pins[lhi_pkg::SER_DATA_BIT]};
            next_wr_is_data = pins[lhi_pkg::PIN_RS];
            next_bit_cnt = lhi_pkg::CNT_RESET;
         end
      end
      if (wr_edge && !busy) begin
         next_wr_valid = 1'b1;
         next_wr_byte = pins[7:0];
         next_wr_is_data = pins[lhi_pkg::PIN_RS];
      end
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         shift_reg <= lhi_pkg::SHIFT_RESET;
         bit_cnt <= lhi_pkg::CNT_RESET;
         wr_valid <= 1'b0;
         wr_byte <= 8'h00;
         wr_is_data <= 1'b0;
         settings_init <= 1'b1;
         prev_e <= 1'b0;
         prev_wr <= 1'b1;
         prev_sclk <= 1'b0;
      end else if (clk_en) begin
         shift_reg <= next_shift_reg;
         bit_cnt <= next_bit_cnt;
         wr_valid <= next_wr_valid;
         wr_byte <= next_wr_byte;
         wr_is_data <= next_wr_is_data;
         settings_init <= next_init;
         prev_e <= pins[lhi_pkg::PIN_E];
         prev_wr <= pins[lhi_pkg::PIN_RW];
         prev_sclk <= pins[lhi_pkg::SER_CLK_BIT];
      end
   end
   // ------------------------------------------------------------
   // Read path and bus drive
   // ------------------------------------------------------------
   always_comb begin
      next_prev_rd = rd_act;
      next_dout = host_data_bus_out;
      next_oe_n = !(rd_act && (!pins[lhi_pkg::PIN_RS] || !busy));
      if (rd_act && !prev_rd) begin
         if (pins[lhi_pkg::PIN_RS]) begin
            next_dout = mem_rdata;
         end else begin
            next_dout = {busy, status_flags, lhi_pkg::STATUS_LOW};
         end
      end
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         prev_rd <= 1'b0;
         host_data_bus_out <= 8'h00;
         host_data_bus_oe_n <= 1'b1;
      end else if (clk_en) begin
         prev_rd <= next_prev_rd;
         host_data_bus_out <= next_dout;
         host_data_bus_oe_n <= next_oe_n;
      end
   end
   // ------------------------------------------------------------
   // Byte FIFO towards the core
   // ------------------------------------------------------------
   lhi_fifo #(.WIDTH(lhi_pkg::FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .clk_en(clk_en),
      .in_valid(wr_valid),
      .in_ready(fifo_ready),
      .in_data({wr_is_data, wr_byte}),
      .out_valid(byte_valid),
      .out_ready(byte_ready),
      .out_data(fifo_out)
   );
   assign byte_is_data = fifo_out[8];
   assign byte_data = fifo_out[7:0];
   // ------------------------------------------------------------
   // Display memory
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (clk_en && mem_wr_en && lhi_in_range(mem_page, mem_col)) begin
         if (mem_page == 4'(lhi_pkg::LAST_PAGE)) begin
            dmem[lhi_addr(mem_page, mem_col)] <= {7'h00, mem_wdata[0]};
         end else begin
            dmem[lhi_addr(mem_page, mem_col)] <= mem_wdata;
         end
      end
   end
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         mem_rdata <= 8'h00;
         pix_on <= 1'b0;
      end else if (clk_en) begin
         mem_rdata <= lhi_in_range(mem_page, mem_col) ? dmem[lhi_addr(mem_page, mem_col)] : 8'h00;
         pix_on <= (pix_row < 7'(lhi_pkg::ROWS)) && lhi_in_range(pix_row[6:3], pix_col)
                   && dmem[lhi_addr(pix_row[6:3], pix_col)][pix_row[2:0]];
      end
   end
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys iff clk_en); endclocking
   default disable iff (!rstn);
   chk_desel_no_drive: assert property (!selected |=> host_data_bus_oe_n)
      else $error("bus driven while deselected");
   chk_serial_no_drive: assert property (port_mode == lhi_pkg::LHI_SERIAL |=> host_data_bus_oe_n)
      else $error("bus driven in serial mode");
   chk_serial_clear: assert property (!selected |=> bit_cnt == 3'h0 && shift_reg == 8'h00)
      else $error("serial state kept while deselected");
   chk_byte_after_eight: assert property (
      port_mode == lhi_pkg::LHI_SERIAL && selected && res_ok && sclk_rise && bit_cnt == 3'h7
      |=> wr_valid && bit_cnt == 3'h0)
      else $error("no byte after eighth edge");
   chk_msb_first_order: assert property (
      port_mode == lhi_pkg::LHI_SERIAL && selected && res_ok && sclk_rise && bit_cnt == 3'h7
      |=> wr_byte == {$past(shift_reg[6:0]), $past(pins[7])})
      else $error("serial byte order wrong");
   chk_rs_flag: assert property ($rose(wr_valid) |-> wr_is_data == $past(pins[12]))
      else $error("data/command flag wrong");
   chk_busy_blocks_write: assert property (busy && wr_edge && !selected == 1'b0
      && port_mode != lhi_pkg::LHI_SERIAL |=> !wr_valid)
      else $error("write taken while busy");
   chk_status_busy_bit: assert property (rd_act && !prev_rd && !pins[12]
      |=> host_data_bus_out[7] == $past(busy) && !host_data_bus_oe_n)
      else $error("status busy bit wrong");
   chk_reset_pin_level: assert property (!res_ok |=> bit_cnt == 3'h0 && !wr_valid
      && settings_init)
      else $error("reset pin level ignored");
   cov_serial_byte: cover property (port_mode == lhi_pkg::LHI_SERIAL ##0 wr_valid);
   cov_parallel_write: cover property (port_mode == lhi_pkg::LHI_P8080 && wr_edge ##1 wr_valid);
   cov_status_read: cover property (rd_act && !pins[12] ##1 !host_data_bus_oe_n);
   cov_fifo_full: cover property (!fifo_ready);
endmodule : lhi_host_port
`default_nettype wire

// File: test/lhi_host_model.sv
// Host processor model driving the controller pins
`timescale 1ns/1ns
`default_nettype none
module lhi_host_model (
   input wire logic clk_sys,
   input wire logic [7:0] bus,
   input wire logic oe_n,
   output logic cs_n,
   output logic cs_h,
   output logic ps,
   output logic c68,
   output logic rs,
   output logic e_rd,
   output logic rw_wr,
   output logic drv,
   output logic [7:0] dq
);
   initial begin
      cs_n = 1'b1;
      cs_h = 1'b0;
      ps = 1'b0;
      c68 = 1'b0;
      rs = 1'b0;
      e_rd = 1'b1;
      rw_wr = 1'b1;
      drv = 1'b1;
      dq = 8'h00;
   end
   // ------------------------------------------------------------
   // Select and mode
   // ------------------------------------------------------------
   task automatic sel(input logic n, input logic h);
      @(negedge clk_sys);
      cs_n = n;
      cs_h = h;
      repeat (4) @(negedge clk_sys);
   endtask : sel
   task automatic mode(input logic p, input logic s);
      sel(1'b1, 1'b0);
      ps = p;
      c68 = s;
      e_rd = !s;
      sel(1'b0, 1'b1);
   endtask : mode
   // ------------------------------------------------------------
   // Transfers
   // ------------------------------------------------------------
   task automatic ser(input logic r, input logic [7:0] b, input int n);
      rs = r;
      for (int i = 0; i < n; i++) begin
         @(negedge clk_sys);
         dq[6] = 1'b0;
         dq[7] = b[7-i];
         repeat (4) @(negedge clk_sys);
         dq[6] = 1'b1;
         repeat (3) @(negedge clk_sys);
      end
      @(negedge clk_sys);
      dq[6] = 1'b0;
   endtask : ser
   task automatic wr(input logic r, input logic [7:0] d);
      @(negedge clk_sys);
      rs = r;
      dq = d;
      rw_wr = 1'b0;
      if (c68) e_rd = 1'b1;
      repeat (4) @(negedge clk_sys);
      if (c68) e_rd = 1'b0;
      else rw_wr = 1'b1;
      repeat (4) @(negedge clk_sys);
      rw_wr = 1'b1;
      repeat (2) @(negedge clk_sys);
   endtask : wr
   task automatic rd(input logic r, output logic [7:0] d, output logic z);
      @(negedge clk_sys);
      rs = r;
      drv = 1'b0;
      e_rd = c68;
      repeat (5) @(negedge clk_sys);
      d = bus;
      z = oe_n;
      e_rd = !c68;
      repeat (4) @(negedge clk_sys);
      drv = 1'b1;
   endtask : rd
endmodule : lhi_host_model
`default_nettype wire

// File: test/testbench.sv
// Self-checking bench for the LCD host port
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk_sys, rstn, res_pin, core_busy, busy, sinit, bv, br, bisd;
   logic mwe, pon, oe_n, cs_n, cs_h, ps, c68, rs, e_rd, rw_wr, drv;
   logic [2:0] flags;
   logic [3:0] mpage;
   logic [6:0] prow;
   logic [7:0] bd, mcol, mwd, mrd, pcol, bus_out, dq, d;
   wire logic [7:0] bus_in;
   logic z;
   int fail_count = 0;
   int n_tests = 0;
   assign bus_in = !oe_n ? bus_out : (drv ? dq : ~dq);
   lhi_host_port #(.FIFO_DEPTH(16)) u_dut (.clk_sys(clk_sys), .rstn(rstn),
      .clk_en(1'b1), .chip_select_low_n(cs_n), .chip_select_high(cs_h),
      .port_type_select(ps), .bus_style_select(c68),
      .data_or_command_select(rs), .enable_or_read_strobe(e_rd),
      .direction_or_write_strobe(rw_wr), .reset_input_low(res_pin),
      .host_data_bus_in(bus_in), .host_data_bus_out(bus_out),
      .host_data_bus_oe_n(oe_n), .core_busy(core_busy), .status_flags(flags),
      .busy(busy), .settings_init(sinit), .byte_valid(bv), .byte_ready(br),
      .byte_data(bd), .byte_is_data(bisd), .mem_wr_en(mwe), .mem_page(mpage),
      .mem_col(mcol), .mem_wdata(mwd), .mem_rdata(mrd), .pix_row(prow),
      .pix_col(pcol), .pix_on(pon));
   lhi_host_model u_host (.clk_sys(clk_sys), .bus(bus_in), .oe_n(oe_n),
      .cs_n(cs_n), .cs_h(cs_h), .ps(ps), .c68(c68), .rs(rs), .e_rd(e_rd),
      .rw_wr(rw_wr), .drv(drv), .dq(dq));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ------------------------------------------------------------
   // Compare and report
   // ------------------------------------------------------------
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8
   task automatic chk1(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask : chk1
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task automatic getb(input logic [7:0] e, input logic f);
      for (int k = 0; k < 30 && bv !== 1'b1; k++) @(negedge clk_sys);
      if (bv !== 1'b1) begin
         fail_count++;
         $display("[ERR] byte_valid expected 1 seen %b", bv);
         summarize();
      end
      chk8("byte_data", e, bd);
      chk1("byte_is_data", f, bisd);
      br = 1'b1;
      @(negedge clk_sys);
      br = 1'b0;
   endtask : getb
   task automatic nob();
      repeat (12) @(negedge clk_sys);
      chk1("byte_valid", 1'b0, bv);
   endtask : nob
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_serial();
      u_host.mode(1'b0, 1'b0);
      u_host.ser(1'b1, 8'ha5, 8);
      getb(8'ha5, 1'b1);
      u_host.ser(1'b0, 8'h3c, 8);
      getb(8'h3c, 1'b0);
      u_host.rd(1'b0, d, z);
      chk1("oe_n", 1'b1, z);
      u_host.ser(1'b1, 8'hff, 3);
      u_host.sel(1'b1, 1'b1);
      u_host.sel(1'b0, 1'b1);
      u_host.ser(1'b0, 8'h81, 8);
      getb(8'h81, 1'b0);
      u_host.sel(1'b0, 1'b0);
      u_host.ser(1'b1, 8'h42, 8);
      nob();
      u_host.sel(1'b1, 1'b1);
      u_host.ser(1'b1, 8'h42, 8);
      nob();
   endtask : t_serial
   task automatic t_parallel();
      u_host.mode(1'b1, 1'b1);
      u_host.wr(1'b1, 8'h5a);
      getb(8'h5a, 1'b1);
      u_host.rd(1'b0, d, z);
      chk8("status", 8'h00, d);
      chk1("oe_n", 1'b0, z);
      u_host.mode(1'b1, 1'b0);
      u_host.wr(1'b0, 8'hc3);
      getb(8'hc3, 1'b0);
      u_host.sel(1'b0, 1'b0);
      u_host.wr(1'b1, 8'h99);
      nob();
      u_host.rd(1'b0, d, z);
      chk1("oe_n", 1'b1, z);
      u_host.sel(1'b0, 1'b1);
   endtask : t_parallel
   task automatic t_busy();
      core_busy = 1'b1;
      flags = 3'h5;
      u_host.rd(1'b0, d, z);
      chk8("status", 8'hd0, d);
      chk1("oe_n", 1'b0, z);
      u_host.wr(1'b1, 8'h11);
      nob();
      u_host.rd(1'b1, d, z);
      chk1("oe_n", 1'b1, z);
      core_busy = 1'b0;
   endtask : t_busy
   task automatic t_fifo();
      for (int i = 0; i < 16; i++) u_host.wr(1'b1, 8'(i));
      repeat (2) @(negedge clk_sys);
      chk1("busy", 1'b1, busy);
      u_host.wr(1'b1, 8'hee);
      for (int i = 0; i < 16; i++) getb(8'(i), 1'b1);
      nob();
      chk1("busy", 1'b0, busy);
   endtask : t_fifo
   task automatic t_mem();
      @(negedge clk_sys);
      mwe = 1'b1;
      mcol = 8'h05;
      mwd = 8'h02;
      @(negedge clk_sys);
      mpage = 4'h8;
      mcol = 8'h00;
      mwd = 8'hff;
      @(negedge clk_sys);
      mwe = 1'b0;
      prow = 7'h40;
      repeat (2) @(negedge clk_sys);
      chk8("mem_rdata", 8'h01, mrd);
      chk1("pix_on", 1'b1, pon);
      mpage = 4'h0;
      mcol = 8'h05;
      prow = 7'h01;
      pcol = 8'h05;
      repeat (2) @(negedge clk_sys);
      chk8("mem_rdata", 8'h02, mrd);
      chk1("pix_on", 1'b1, pon);
      prow = 7'h00;
      repeat (2) @(negedge clk_sys);
      chk1("pix_on", 1'b0, pon);
      u_host.rd(1'b1, d, z);
      u_host.rd(1'b1, d, z);
      chk8("display read", 8'h02, d);
   endtask : t_mem
   task automatic t_respin();
      res_pin = 1'b0;
      repeat (5) @(negedge clk_sys);
      chk1("settings_init", 1'b1, sinit);
      u_host.wr(1'b1, 8'h77);
      nob();
      res_pin = 1'b1;
      repeat (5) @(negedge clk_sys);
      chk1("settings_init", 1'b0, sinit);
   endtask : t_respin
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rstn = 1'b0;
      res_pin = 1'b1;
      core_busy = 1'b0;
      flags = 3'h0;
      br = 1'b0;
      mwe = 1'b0;
      mpage = 4'h0;
      mcol = 8'h00;
      mwd = 8'h00;
      prow = 7'h00;
      pcol = 8'h00;
      repeat (4) @(negedge clk_sys);
      chk1("oe_n", 1'b1, oe_n);
      chk1("settings_init", 1'b1, sinit);
      chk1("byte_valid", 1'b0, bv);
      rstn = 1'b1;
      repeat (3) @(negedge clk_sys);
      t_serial();
      t_parallel();
      t_busy();
      t_fifo();
      t_mem();
      t_respin();
      summarize();
   end
endmodule : testbench
`default_nettype wire
